// ===== logic/pic_pkg.sv
// shared constants and types of the pin cell
package pic_pkg;

	localparam int unsigned ADDR_W      = 4;
	localparam int unsigned DATA_W      = 32;

	localparam logic [3:0]  OFS_CTRL    = 4'h0;
	localparam logic [3:0]  OFS_TX      = 4'h4;
	localparam logic [3:0]  OFS_STATUS  = 4'h8;
	localparam logic [3:0]  OFS_RX      = 4'hC;

	// control register fields
	localparam int unsigned CTRL_MODE_LSB  = 0;
	localparam int unsigned CTRL_ALIGN_BIT = 2;
	localparam int unsigned CTRL_SCLR_BIT  = 3;

	// transmit word fields
	localparam int unsigned TX_HI_BIT   = 0;
	localparam int unsigned TX_LO_BIT   = 1;
	localparam int unsigned TX_OE_BIT   = 2;

	// status register fields
	localparam int unsigned ST_FULL_BIT  = 0;
	localparam int unsigned ST_EMPTY_BIT = 1;
	localparam int unsigned ST_OVF_BIT   = 2;

	localparam int unsigned RX_PAIR_LSB = 0;

	localparam int unsigned FIFO_W      = 3;
	localparam int unsigned FIFO_D      = 16;

	typedef enum logic [1:0]
	{
		PIC_MODE_IN    = 2'h0,
		PIC_MODE_OUT   = 2'h1,
		PIC_MODE_BIDIR = 2'h2,
		PIC_MODE_RSVD  = 2'h3
	} pic_mode_e;

	localparam pic_mode_e   RST_MODE    = PIC_MODE_IN;
	localparam logic        RST_ALIGN   = 1'b0;
	localparam logic        RST_SCLR    = 1'b0;
	localparam logic        RST_OVF     = 1'b0;

	// power-up level of the six pin registers, index order:
	// 0 in_rise, 1 in_fall, 2 out_hi, 3 out_lo, 4 oe_hi, 5 oe_lo
	localparam logic [5:0]  RST_PWRUP   = 6'h00;

endpackage

// ===== logic/pic_fifo_if.sv
// valid/ready carrier between the pin cell and its transmit fifo
`timescale 1ns/1ns
interface pic_fifo_if #(parameter int unsigned W = 3);
	logic         wr_valid;
	logic         wr_ready;
	logic [W-1:0] wr_data;
	logic         rd_valid;
	logic         rd_ready;
	logic [W-1:0] rd_data;

	modport src  (output wr_valid, output wr_data, input wr_ready);
	modport fifo (input wr_valid, input wr_data, output wr_ready,
		output rd_valid, output rd_data, input rd_ready);
	modport snk  (input rd_valid, input rd_data, output rd_ready);
endinterface

// ===== logic/pic_mem.sv
// small storage array with registered, write-first read port
`timescale 1ns/1ns
module pic_mem
#(
	parameter int unsigned W  = 3,
	parameter int unsigned AW = 4
)
(
	input  wire logic          clk,
	input  wire logic          we,
	input  wire logic [AW-1:0] waddr,
	input  wire logic [W-1:0]  wdata,
	input  wire logic [AW-1:0] raddr,
	output logic      [W-1:0]  rdata_r
);
	logic [W-1:0] mem [0:(1<<AW)-1];

	always_ff @(posedge clk)
	begin
		if (we)
			mem[waddr] <= wdata;
	end

	// bypass so a word written into the read slot is seen at once
	always_ff @(posedge clk)
	begin
		if (we && (waddr == raddr))
			rdata_r <= wdata;
		else
			rdata_r <= mem[raddr];
	end
endmodule

// ===== logic/pic_fifo.sv
// parameterised fifo with valid/ready on both sides
`timescale 1ns/1ns
module pic_fifo
#(
	parameter int unsigned W = 3,
	parameter int unsigned D = 16
)
(
	input  wire logic clk,
	input  wire logic rstn,
	pic_fifo_if.fifo  q
);
	localparam int unsigned AW = $clog2(D);

	logic [AW-1:0] wr_ptr_r;
	logic [AW-1:0] rd_ptr_r;
	logic [AW:0]   count_r;
	logic          push;
	logic          pop;
	logic [AW-1:0] rd_addr;

	assign q.wr_ready = (count_r != D[AW:0]);
	assign q.rd_valid = (count_r != '0);
	assign push       = q.wr_valid && q.wr_ready;
	assign pop        = q.rd_valid && q.rd_ready;
	// look one slot ahead on a pop so the head word is ready next cycle
	assign rd_addr    = pop ? AW'(rd_ptr_r + 1'b1) : rd_ptr_r;

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
		end
		else
		begin
			if (push)
				wr_ptr_r <= AW'(wr_ptr_r + 1'b1);
			if (pop)
				rd_ptr_r <= AW'(rd_ptr_r + 1'b1);
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
			count_r <= '0;
		else if (push && !pop)
			count_r <= (AW+1)'(count_r + 1'b1);
		else if (pop && !push)
			count_r <= (AW+1)'(count_r - 1'b1);
	end

	pic_mem #(.W(W), .AW(AW)) u_mem
	(
		.clk     (clk),
		.we      (push),
		.waddr   (wr_ptr_r),
		.wdata   (q.wr_data),
		.raddr   (rd_addr),
		.rdata_r (q.rd_data)
	);
endmodule

// ===== logic/pic_cell.sv
// one programmable pin cell with ddr input, output and output-enable registers
//
// Added by the designer: the placing of the registers and the strobed register port.
`timescale 1ns/1ns

module pic_cell
	import pic_pkg::*;
#(
	parameter logic [5:0] PWRUP = RST_PWRUP
)
(
	input  wire logic              clk,
	input  wire logic              rstn,
	input  wire logic              aclr_n,
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [DATA_W-1:0] wr_data,
	input  wire logic              wr_stb,
	input  wire logic              rd_stb,
	output logic      [DATA_W-1:0] rd_data_r,
	output logic                   tx_ready_r,
	input  wire logic              pin_in,
	output logic                   pin_out,
	output logic                   pin_oe
);

	pic_mode_e          mode_r;
	logic               align_fall_r;
	logic               sclr_r;
	logic               ovf_r;
	logic               cell_sclr;

	// six pin registers
	logic               in_rise_r;
	logic               in_fall_r;
	logic               out_hi_r;
	logic               out_lo_r;
	logic               oe_hi_r;
	logic               oe_lo_r;

	logic               rise_latch;
	logic [1:0]         pair_rise_r;
	logic [1:0]         pair_fall_r;
	logic [1:0]         rx_pair_r;

	logic               stage_lo_r;
	logic               stage_oe_r;
	logic               out_hi_nxt;
	logic               stage_lo_nxt;
	logic               oe_nxt;
	logic               pop;

	logic               wr_ctrl;
	logic               wr_tx;
	logic               wr_status;
	logic [DATA_W-1:0]  rd_nxt;
	logic               full_r;
	logic               empty_r;

	pic_fifo_if #(.W(FIFO_W)) txq ();

	// pin registers share aclr_n; the level they fall to is their power-up level
	assign cell_sclr = !rstn || sclr_r;

	assign wr_ctrl   = wr_stb && (addr == OFS_CTRL);
	assign wr_tx     = wr_stb && (addr == OFS_TX);
	assign wr_status = wr_stb && (addr == OFS_STATUS);

	// register bus: control
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			mode_r       <= RST_MODE;
			align_fall_r <= RST_ALIGN;
			sclr_r       <= RST_SCLR;
		end
		else if (wr_ctrl)
		begin
			mode_r       <= pic_mode_e'(wr_data[CTRL_MODE_LSB +: 2]);
			align_fall_r <= wr_data[CTRL_ALIGN_BIT];
			sclr_r       <= wr_data[CTRL_SCLR_BIT];
		end
	end

	// overflow: a dropped push while the clear lands still sets
	always_ff @(posedge clk)
	begin
		if (!rstn)
			ovf_r <= RST_OVF;
		else if (wr_tx && !txq.wr_ready)
			ovf_r <= 1'b1;
		else if (wr_status && wr_data[ST_OVF_BIT])
			ovf_r <= 1'b0;
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			full_r     <= 1'b0;
			empty_r    <= 1'b1;
			tx_ready_r <= 1'b0;
		end
		else
		begin
			full_r     <= !txq.wr_ready;
			empty_r    <= !txq.rd_valid;
			tx_ready_r <= txq.wr_ready;
		end
	end

	assign txq.wr_valid = wr_tx;
	assign txq.wr_data  = wr_data[FIFO_W-1:0];

	always_comb
	begin
		rd_nxt = '0;
		case (addr)
			OFS_CTRL:
			begin
				rd_nxt[CTRL_MODE_LSB +: 2] = mode_r;
				rd_nxt[CTRL_ALIGN_BIT]     = align_fall_r;
				rd_nxt[CTRL_SCLR_BIT]      = sclr_r;
			end
			OFS_STATUS:
			begin
				rd_nxt[ST_FULL_BIT]  = full_r;
				rd_nxt[ST_EMPTY_BIT] = empty_r;
				rd_nxt[ST_OVF_BIT]   = ovf_r;
			end
			OFS_RX:
				rd_nxt[RX_PAIR_LSB +: 2] = rx_pair_r;
			default:
				rd_nxt = '0;
		endcase
	end

	// read data stand for exactly the cycle after the strobe
	always_ff @(posedge clk)
	begin
		if (!rstn)
			rd_data_r <= '0;
		else if (rd_stb)
			rd_data_r <= rd_nxt;
		else
			rd_data_r <= '0;
	end

	pic_fifo #(.W(FIFO_W), .D(FIFO_D)) u_txq
	(
		.clk  (clk),
		.rstn (rstn),
		.q    (txq.fifo)
	);

	// input pair: rising-edge sample
	always_ff @(posedge clk or negedge aclr_n)
	begin
		if (!aclr_n)
			in_rise_r <= PWRUP[0];
		else if (cell_sclr)
			in_rise_r <= PWRUP[0];
		else
			in_rise_r <= pin_in;
	end

	// input pair: falling-edge sample
	always_ff @(negedge clk or negedge aclr_n)
	begin
		if (!aclr_n)
			in_fall_r <= PWRUP[1];
		else if (cell_sclr)
			in_fall_r <= PWRUP[1];
		else
			in_fall_r <= pin_in;
	end

	// keeps the rising bit alive through the low phase for the falling-edge pair
	always_latch
	begin
		if (clk)
			rise_latch <= in_rise_r;
	end

	always_ff @(posedge clk)
	begin
		if (cell_sclr)
			pair_rise_r <= 2'h0;
		else
			pair_rise_r <= {in_rise_r, in_fall_r};
	end

	// falling pair joins this period's rising bit with the previous falling bit
	always_ff @(negedge clk)
	begin
		if (cell_sclr)
			pair_fall_r <= 2'h0;
		else
			pair_fall_r <= {rise_latch, in_fall_r};
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
			rx_pair_r <= 2'h0;
		else if (mode_r == PIC_MODE_OUT)
			rx_pair_r <= 2'h0;
		else
			rx_pair_r <= align_fall_r ? pair_fall_r : pair_rise_r;
	end

	// transmit: one fifo word per period, except in input-only mode or while cell_sclr is set
	assign pop          = txq.rd_valid && (mode_r != PIC_MODE_IN) && !cell_sclr;
	assign txq.rd_ready = pop;

	always_comb
	begin
		out_hi_nxt   = out_hi_r;
		stage_lo_nxt = stage_lo_r;
		oe_nxt       = 1'b0;
		case (mode_r)
			PIC_MODE_OUT:
			begin
				oe_nxt = 1'b1;
				if (pop)
				begin
					out_hi_nxt   = txq.rd_data[TX_HI_BIT];
					stage_lo_nxt = txq.rd_data[TX_LO_BIT];
				end
			end
			PIC_MODE_BIDIR:
			begin
				// an empty queue releases the pin so the far end may drive
				if (pop)
				begin
					out_hi_nxt   = txq.rd_data[TX_HI_BIT];
					stage_lo_nxt = txq.rd_data[TX_LO_BIT];
					oe_nxt       = txq.rd_data[TX_OE_BIT];
				end
			end
			default:
				oe_nxt = 1'b0;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (cell_sclr)
		begin
			stage_lo_r <= PWRUP[3];
			stage_oe_r <= PWRUP[5];
		end
		else
		begin
			stage_lo_r <= stage_lo_nxt;
			stage_oe_r <= oe_nxt;
		end
	end

	always_ff @(posedge clk or negedge aclr_n)
	begin
		if (!aclr_n)
		begin
			out_hi_r <= PWRUP[2];
			oe_hi_r  <= PWRUP[4];
		end
		else if (cell_sclr)
		begin
			out_hi_r <= PWRUP[2];
			oe_hi_r  <= PWRUP[4];
		end
		else
		begin
			out_hi_r <= out_hi_nxt;
			oe_hi_r  <= oe_nxt;
		end
	end

	always_ff @(negedge clk or negedge aclr_n)
	begin
		if (!aclr_n)
		begin
			out_lo_r <= PWRUP[3];
			oe_lo_r  <= PWRUP[5];
		end
		else if (cell_sclr)
		begin
			out_lo_r <= PWRUP[3];
			oe_lo_r  <= PWRUP[5];
		end
		else
		begin
			out_lo_r <= stage_lo_r;
			oe_lo_r  <= stage_oe_r;
		end
	end

	// clock-phase select is the ddr launch itself, so these two are not flopped
	assign pin_out = clk ? out_hi_r : out_lo_r;
	assign pin_oe  = clk ? oe_hi_r : oe_lo_r;

endmodule

// ===== sim/pic_cell_checker.sv
// concurrent checks on the pin cell ports
`timescale 1ns/1ns
module pic_cell_checker
	import pic_pkg::*;
#(
	parameter logic [5:0] PWRUP = RST_PWRUP
)
(
	input wire logic              clk,
	input wire logic              rstn,
	input wire logic              aclr_n,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] wr_data,
	input wire logic              wr_stb,
	input wire logic              rd_stb,
	input wire logic [DATA_W-1:0] rd_data_r,
	input wire logic              tx_ready_r,
	input wire logic              pin_in,
	input wire logic              pin_out,
	input wire logic              pin_oe
);
	logic [3:0] ctl_r;
	wire  logic quiet;
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	always_ff @(posedge clk)
	begin
		if (!rstn)
			ctl_r <= 4'h0;
		else if (wr_stb && addr == OFS_CTRL)
			ctl_r <= wr_data[3:0];
	end
	// input or reserved mode with no reset of any kind in force
	// reset loads the power-up levels, which may drive, so it is not quiet
	assign quiet = rstn && aclr_n && !ctl_r[3] && ctl_r[1:0] != 2'h1 && ctl_r[1:0] != 2'h2;
	read_idle_a: assert property (!rd_stb |=> rd_data_r == 32'h0)
		else $error("read data not cleared");
	tx_readback_a: assert property (rd_stb && addr == OFS_TX |=> rd_data_r == 32'h0)
		else $error("transmit word readable");
	unmapped_read_a: assert property (rd_stb && addr[1:0] != 2'h0 |=> rd_data_r == 32'h0)
		else $error("unmapped read not zero");
	ctrl_readback_a: assert property (rd_stb && addr == OFS_CTRL |=> rd_data_r == {28'h0, ctl_r})
		else $error("control readback wrong");
	status_form_a: assert property (rd_stb && addr == OFS_STATUS |=>
		rd_data_r[31:3] == 29'h0 && !(rd_data_r[0] && rd_data_r[1])) else $error("status malformed");
	rx_form_a: assert property (rd_stb && addr == OFS_RX |=> rd_data_r[31:2] == 30'h0)
		else $error("receive pair malformed");
	rx_out_zero_a: assert property (rd_stb && addr == OFS_RX && ctl_r[1:0] == 2'h1
		&& $past(ctl_r[1:0]) == 2'h1 |=> rd_data_r == 32'h0) else $error("receive pair in output mode");
	aclr_force_a: assert property (!aclr_n && !$past(aclr_n) |->
		pin_out == PWRUP[3] && pin_oe == PWRUP[5]) else $error("async control level wrong");
	in_no_drive_a: assert property (quiet && $past(quiet) && $past(quiet, 2) |-> !pin_oe)
		else $error("pin driven in input mode");
endmodule

bind pic_cell pic_cell_checker #(.PWRUP(PWRUP)) pic_cell_checker_inst (.clk(clk), .rstn(rstn),
	.aclr_n(aclr_n), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb),
	.rd_data_r(rd_data_r), .tx_ready_r(tx_ready_r), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));

// ===== sim/pic_pad_model.sv
// pad-side ddr source; the wire follows the cell whenever it drives
`timescale 1ns/1ns
module pic_pad_model
(
	input  wire logic clk,
	input  wire logic rise_bit,
	input  wire logic fall_bit,
	input  wire logic pin_out,
	input  wire logic pin_oe,
	output logic      pin_in
);
	logic drv = 1'b0;
	// launch each bit a quarter period (1 ns) early so it is settled at its capture edge
	always @(clk) drv <= #1 (clk ? fall_bit : rise_bit);
	assign pin_in = pin_oe ? pin_out : drv;
endmodule

// ===== sim/pic_cell_tb_top.sv
// self-checking bench of the pin cell
`timescale 1ns/1ns
module pic_cell_tb_top;
	import pic_pkg::*;
	// mixed levels so both clear and preset behaviour show
	localparam logic [5:0] PWRUP = 6'h2A;
	logic              clk = 1'b0;
	logic              rstn = 1'b0;
	logic              aclr_n = 1'b1;
	logic [3:0]        addr = 4'h0;
	logic [31:0]       wr_data = 32'h0;
	logic              wr_stb = 1'b0;
	logic              rd_stb = 1'b0;
	logic              rise_bit = 1'b0;
	logic              fall_bit = 1'b0;
	logic              rd_seen = 1'b0;
	logic [31:0]       rd_data_r;
	logic              tx_ready_r;
	logic              pin_in;
	logic              pin_out;
	logic              pin_oe;
	logic [31:0]       exp_q[$];
	int                n_errors = 0;
	int                checked = 0;
	always #2 clk = ~clk;
	pic_cell #(.PWRUP(PWRUP)) pic_cell_inst (.clk(clk), .rstn(rstn), .aclr_n(aclr_n), .addr(addr),
		.wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data_r(rd_data_r),
		.tx_ready_r(tx_ready_r), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
	pic_pad_model pic_pad_model_inst (.clk(clk), .rise_bit(rise_bit), .fall_bit(fall_bit),
		.pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in));
	task automatic ck(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic conclude();
		$display("mismatches %0d of %0d comparisons", n_errors, checked);
		if (n_errors == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		addr <= a;
		wr_data <= d;
		wr_stb <= 1'b1;
		@(posedge clk);
		wr_stb <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		addr <= a;
		rd_stb <= 1'b1;
		exp_q.push_back(e);
		@(posedge clk);
		rd_stb <= 1'b0;
		@(posedge clk);
	endtask
	// checks the current high phase, then the following low phase
	task automatic pk(input logic hi, input logic oeh, input logic lo, input logic oel);
		#1 ck({30'h0, pin_out, pin_oe}, {30'h0, hi, oeh});
		@(negedge clk);
		#1 ck({30'h0, pin_out, pin_oe}, {30'h0, lo, oel});
		@(posedge clk);
	endtask
	always @(posedge clk)
	begin
		if (rd_seen)
			ck(rd_data_r, exp_q.pop_front());
		rd_seen <= rd_stb;
	end
	initial
	begin
		repeat (20000) @(posedge clk);
		n_errors++;
		conclude();
	end
	initial
	begin
		void'($urandom(32'hA56D0950));
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		rd(OFS_CTRL, 32'h0);
		ck({31'h0, tx_ready_r}, 32'h1);
		rd(OFS_STATUS, 32'h2);
		rd(OFS_TX, 32'h0);
		rd(4'h1 | 4'($urandom & 32'hE), 32'h0);
		for (int i = 0; i < 16; i++)
		begin
			rise_bit <= i[0];
			fall_bit <= i[1];
			// bit 2 of i picks the aligning edge, bit 3 input or reserved mode
			wr(OFS_CTRL, ($urandom & 32'hFFFFFFF0) | {28'h0, 1'b0, i[2], i[3], i[3]});
			repeat (4) @(posedge clk);
			rd(OFS_RX, {30'h0, i[0], i[1]});
		end
		wr(OFS_CTRL, 32'h0);
		// input mode leaves the fifo undrained, so it fills and refuses
		for (int i = 0; i < 17; i++)
			wr(OFS_TX, $urandom & 32'h7);
		ck({31'h0, tx_ready_r}, 32'h0);
		rd(OFS_STATUS, 32'h5);
		wr(OFS_STATUS, 32'h4);
		rd(OFS_STATUS, 32'h1);
		wr(OFS_CTRL, 32'h1);
		repeat (24) @(posedge clk);
		rd(OFS_STATUS, 32'h2);
		for (int i = 0; i < 4; i++)
		begin
			wr(OFS_TX, i);
			repeat (2) @(posedge clk);
			pk(i[0], 1'b1, i[1], 1'b1);
		end
		wr(OFS_CTRL, 32'h2);
		wr(OFS_TX, 32'h6);
		pk(1'b0, 1'b1, 1'b1, 1'b1);
		repeat (2) @(posedge clk);
		#1 ck({31'h0, pin_oe}, 32'h0);
		@(posedge clk);
		wr(OFS_TX, 32'h3);
		#1 ck({31'h0, pin_oe}, 32'h0);
		@(posedge clk);
		wr(OFS_CTRL, 32'h9);
		repeat (2) @(posedge clk);
		pk(PWRUP[2], PWRUP[4], PWRUP[3], PWRUP[5]);
		wr(OFS_CTRL, 32'h1);
		wr(OFS_TX, 32'h1);
		repeat (2) @(posedge clk);
		aclr_n <= 1'b0;
		pk(PWRUP[2], PWRUP[4], PWRUP[3], PWRUP[5]);
		repeat (2) @(posedge clk);
		aclr_n <= 1'b1;
		@(posedge clk);
		wr(OFS_TX, 32'h1);
		pk(1'b1, 1'b1, 1'b0, 1'b1);
		rd(OFS_RX, 32'h0);
		repeat (2) @(posedge clk);
		conclude();
	end
endmodule
